/* include/artc_pkg.sv */
package artc_pkg;
    // register word offsets on the avalon bus (byte addresses)
    localparam logic [3:0] OFF_RESULT  = 4'h0;
    localparam logic [3:0] OFF_CTRL0   = 4'h4;
    localparam logic [3:0] OFF_CTRL1   = 4'h8;
    localparam logic [3:0] OFF_START   = 4'hc;
    localparam logic [3:0] OFF_FORMAT  = 4'h0 + 4'h0;
    // own registers
    localparam logic [4:0] OFF_CFG     = 5'h10;
    localparam logic [4:0] OFF_STATUS  = 5'h14;
    localparam logic [4:0] OFF_MASK    = 5'h18;
    localparam int ADDR_W = 5;
    // control register 0 fields
    localparam int TB_BIT    = 3;
    localparam int CT_BIT    = 2;
    localparam int B1_BIT    = 1;
    localparam int FETCH_BIT = 0;
    // config register field
    localparam int FMT_BIT   = 0;
    // status / mask fields
    localparam int ST_BLOCK  = 0;
    localparam int ST_RESULT = 1;
    localparam int ST_W      = 2;
    // reset values, and the address step per word
    localparam logic [3:0]  CTRL0_RST = 4'h0;
    localparam logic [7:0]  CTRL1_RST = 8'h00;
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    typedef enum logic [1:0] {ARTC_IDLE, ARTC_WAIT, ARTC_WRITE}
        artc_state_t;
endpackage : artc_pkg

/* core/artc_format.sv */
`timescale 1ns/1ps
module artc_format #(
    parameter int RES_W = 10
) (
    input  wire logic [RES_W-1:0] rawValue,
    input  wire logic             twosComp,
    output logic [15:0]           formatted
);
    // sign flip and zero padding each need a spare bit
    if (RES_W < 2 || RES_W > 15) begin : g_bad_width
        $error("artc_format: RES_W out of range");
    end

    always_comb begin
        if (twosComp) begin
            // left justified, offset binary flipped to signed
            formatted = {~rawValue[RES_W-1], rawValue[RES_W-2:0],
                         {(16-RES_W){1'b0}}};
        end else begin
            formatted = {{(16-RES_W){1'b0}}, rawValue};
        end
    end
endmodule : artc_format

/* core/artc_transfer.sv */
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Functional notes
// - binary format: right justified, top bits zero
// - twos complement: left justified, low six zero
// - control 0 bits 7-4 read zero
// - control 0 bit 3 selects two-block mode
// - non-continuous: stop after one/two blocks
// - continuous: run until bit cleared or restart
// - block indicator reports last filled block
// - count zero disables, else transfers per block
// - start address write begins a run
// - start address bit 0 reads zero
// - completion flag set per block
// - format bit: zero binary, one twos complement
module artc_transfer #(
    parameter int RES_W = 10
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [artc_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic [RES_W-1:0]             convData,
    input  wire logic                         convDone,
    output logic                              memWrite,
    output logic [15:0]                       memAddress,
    output logic [15:0]                       memWriteData,
    input  wire logic                         memWaitrequest,
    output logic                              irq
);
    if (RES_W != 10) begin : g_bad_width
        $error("artc_transfer: only a 10-bit result is served");
    end

    logic [3:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [15:0] startAddr;
    logic        fmtSel;
    logic [artc_pkg::ST_W-1:0] status;
    logic [artc_pkg::ST_W-1:0] mask;
    logic [RES_W-1:0] rawResult;
    logic [15:0] resultWord;
    logic        readDone;
    logic [31:0] next_readdata;

    artc_pkg::artc_state_t state;
    logic [7:0]  xferCount;
    logic        secondBlock;
    logic [15:0] newWord;
    logic [15:0] next_startAddr;
    logic [15:0] curAddr;
    logic [15:0] pendData;
    logic        blockEnd;
    logic        runEnd;

    logic regWrite;
    logic regRead;
    logic startWrite;
    assign regWrite   = avs_write && !avs_waitrequest;
    assign regRead    = avs_read && !avs_waitrequest;
    assign startWrite = regWrite && avs_address == 5'(artc_pkg::OFF_START)
                        && avs_byteenable[0];
    // a low-lane-only write keeps the old high byte
    assign next_startAddr = {avs_byteenable[1] ? avs_writedata[15:8]
                                               : startAddr[15:8],
                             avs_writedata[7:1], 1'b0};

    // one wait state on reads so readdata comes from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readDone <= 1'b0;
        end else begin
            readDone <= avs_read && !readDone;
        end
    end
    assign avs_waitrequest = avs_read && !readDone;

    artc_format #(
        .RES_W (RES_W)
    ) u_format (
        .rawValue  (rawResult),
        .twosComp  (fmtSel),
        .formatted (resultWord)
    );

    // the latch lags convDone by a cycle, so format the live sample
    artc_format #(
        .RES_W (RES_W)
    ) u_formatNew (
        .rawValue  (convData),
        .twosComp  (fmtSel),
        .formatted (newWord)
    );

    function automatic logic [31:0] read_mux(
        input logic [artc_pkg::ADDR_W-1:0] a,
        input logic [3:0]  c0,
        input logic [7:0]  c1,
        input logic [15:0] sa,
        input logic [15:0] res,
        input logic        fmt,
        input logic [artc_pkg::ST_W-1:0] st,
        input logic [artc_pkg::ST_W-1:0] mk
    );
        unique case (a)
            5'(artc_pkg::OFF_RESULT): read_mux = {16'h0000, res};
            5'(artc_pkg::OFF_CTRL0):  read_mux = {28'h0000000, c0};
            5'(artc_pkg::OFF_CTRL1):  read_mux = {24'h000000, c1};
            5'(artc_pkg::OFF_START):
                read_mux = {16'h0000, sa[15:1], 1'b0};
            artc_pkg::OFF_CFG:    read_mux = {31'h00000000, fmt};
            artc_pkg::OFF_STATUS: read_mux = {30'h00000000, st};
            artc_pkg::OFF_MASK:   read_mux = {30'h00000000, mk};
            default:              read_mux = 32'h00000000;
        endcase
    endfunction : read_mux

    assign next_readdata = read_mux(avs_address, ctrl0, ctrl1, startAddr,
                                    resultWord, fmtSel, status, mask);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read) begin
            avs_readdata <= next_readdata;
        end
    end

    // control registers; block indicator is hardware owned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl0 <= artc_pkg::CTRL0_RST;
        end else begin
            if (regWrite && avs_address == 5'(artc_pkg::OFF_CTRL0)
                && avs_byteenable[0]) begin
                ctrl0[artc_pkg::TB_BIT]    <= avs_writedata[artc_pkg::TB_BIT];
                ctrl0[artc_pkg::CT_BIT]    <= avs_writedata[artc_pkg::CT_BIT];
                // fetch bit stored only; expected to stay clear
                ctrl0[artc_pkg::FETCH_BIT] <=
                    avs_writedata[artc_pkg::FETCH_BIT];
            end
            if (startWrite) begin
                ctrl0[artc_pkg::B1_BIT] <= 1'b0;
            end else if (blockEnd && ctrl0[artc_pkg::TB_BIT]) begin
                ctrl0[artc_pkg::B1_BIT] <= secondBlock;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl1     <= artc_pkg::CTRL1_RST;
            startAddr <= artc_pkg::START_RST;
            fmtSel    <= 1'b0;
            mask      <= '0;
        end else if (regWrite) begin
            if (avs_address == 5'(artc_pkg::OFF_CTRL1) && avs_byteenable[0])
                ctrl1 <= avs_writedata[7:0];
            if (startWrite)
                startAddr <= next_startAddr;
            if (avs_address == artc_pkg::OFF_CFG && avs_byteenable[0])
                fmtSel <= avs_writedata[artc_pkg::FMT_BIT];
            if (avs_address == artc_pkg::OFF_MASK && avs_byteenable[0])
                mask <= avs_writedata[artc_pkg::ST_W-1:0];
        end
    end

    // conversion result latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rawResult <= '0;
        end else if (convDone) begin
            rawResult <= convData;
        end
    end

    assign blockEnd = state == artc_pkg::ARTC_WRITE && !memWaitrequest
                      && xferCount == ctrl1 - 8'h01;
    // a cleared continuous bit only stops at a pass boundary
    assign runEnd   = blockEnd && !ctrl0[artc_pkg::CT_BIT]
                      && (!ctrl0[artc_pkg::TB_BIT] || secondBlock);

    // transfer engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= artc_pkg::ARTC_IDLE;
            xferCount   <= 8'h00;
            secondBlock <= 1'b0;
            curAddr     <= 16'h0000;
            pendData    <= 16'h0000;
        end else if (startWrite) begin
            // restart drops any run in flight
            state       <= artc_pkg::ARTC_WAIT;
            xferCount   <= 8'h00;
            secondBlock <= 1'b0;
            curAddr     <= next_startAddr;
        end else begin
            unique case (state)
                artc_pkg::ARTC_IDLE: ;
                artc_pkg::ARTC_WAIT: begin
                    if (ctrl1 == 8'h00) begin
                        state <= artc_pkg::ARTC_IDLE;
                    end else if (convDone) begin
                        pendData <= newWord;
                        state    <= artc_pkg::ARTC_WRITE;
                    end
                end
                artc_pkg::ARTC_WRITE: begin
                    if (!memWaitrequest) begin
                        curAddr <= curAddr + artc_pkg::WORD_STEP;
                        if (runEnd) begin
                            state <= artc_pkg::ARTC_IDLE;
                        end else begin
                            state <= artc_pkg::ARTC_WAIT;
                        end
                        if (blockEnd) begin
                            xferCount <= 8'h00;
                            if (ctrl0[artc_pkg::TB_BIT]) begin
                                secondBlock <= !secondBlock;
                                if (secondBlock) begin
                                    curAddr <= startAddr;
                                end
                            end else begin
                                curAddr <= startAddr;
                            end
                        end else begin
                            xferCount <= xferCount + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    assign memWrite     = state == artc_pkg::ARTC_WRITE;
    assign memAddress   = curAddr;
    assign memWriteData = pendData;

    // sticky events, cleared by a read of the status word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else begin
            for (int i = 0; i < artc_pkg::ST_W; i++) begin
                if ((i == artc_pkg::ST_BLOCK && blockEnd)
                    || (i == artc_pkg::ST_RESULT && convDone
                        && state == artc_pkg::ARTC_IDLE)) begin
                    status[i] <= 1'b1;
                end else if (regRead
                             && avs_address == artc_pkg::OFF_STATUS) begin
                    status[i] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(status & mask);

    block_flag_a: assert property (@(posedge clk)
        disable iff (rst) blockEnd |=> status[artc_pkg::ST_BLOCK])
        else $error("block end did not set flag");
    bin_zero_a: assert property (@(posedge clk)
        disable iff (rst) !fmtSel |-> resultWord[15:10] == 6'h00)
        else $error("binary top bits not zero");
    twos_zero_a: assert property (@(posedge clk)
        disable iff (rst) fmtSel |-> resultWord[5:0] == 6'h00)
        else $error("twos low bits not zero");
    ctrl_hi_a: assert property (@(posedge clk)
        disable iff (rst)
        regRead && avs_address == 5'(artc_pkg::OFF_CTRL0)
        |=> avs_readdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    sa_low_a: assert property (@(posedge clk)
        disable iff (rst) startAddr[0] == 1'b0)
        else $error("start address bit 0 set");
    addr_step_a: assert property (@(posedge clk)
        disable iff (rst)
        memWrite && !memWaitrequest && !blockEnd && !startWrite
        |=> memAddress == $past(memAddress) + 16'h0002)
        else $error("address did not step a word");
    zero_count_a: assert property (@(posedge clk)
        disable iff (rst)
        ctrl1 == 8'h00 && state == artc_pkg::ARTC_WAIT && !startWrite
        |=> state == artc_pkg::ARTC_IDLE)
        else $error("zero count did not disable");
    start_run_a: assert property (@(posedge clk)
        disable iff (rst) startWrite |=> state == artc_pkg::ARTC_WAIT)
        else $error("start write did not begin run");
    one_block_a: assert property (@(posedge clk)
        disable iff (rst)
        runEnd && !startWrite |=> state == artc_pkg::ARTC_IDLE)
        else $error("single run did not stop");
    indicator_a: assert property (@(posedge clk)
        disable iff (rst)
        blockEnd && ctrl0[artc_pkg::TB_BIT] && !startWrite
        |=> ctrl0[artc_pkg::B1_BIT] == $past(secondBlock))
        else $error("block indicator wrong");
    mem_hold_a: assert property (@(posedge clk)
        disable iff (rst)
        memWrite && memWaitrequest && !startWrite
        |=> memWrite && $stable(memAddress) && $stable(memWriteData))
        else $error("memory request changed while stalled");
    result_latch_a: assert property (@(posedge clk)
        disable iff (rst) convDone |=> rawResult == $past(convData))
        else $error("result not latched");
    status_clr_a: assert property (@(posedge clk)
        disable iff (rst)
        regRead && avs_address == artc_pkg::OFF_STATUS && !blockEnd
        |=> !status[artc_pkg::ST_BLOCK])
        else $error("status read did not clear flag");
    restart_c: cover property (@(posedge clk) disable iff (rst)
        startWrite && state != artc_pkg::ARTC_IDLE);
    cont_run_c: cover property (@(posedge clk) disable iff (rst)
        blockEnd && ctrl0[artc_pkg::CT_BIT]);
    two_block_c: cover property (@(posedge clk) disable iff (rst)
        blockEnd && secondBlock);
    irq_c: cover property (@(posedge clk) disable iff (rst) irq);
endmodule : artc_transfer

/* verification/artc_mem_model.sv */
`timescale 1ns/1ps
module artc_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  stallCycles,
    input  wire logic        memWrite,
    input  wire logic [15:0] memAddress,
    input  wire logic [15:0] memWriteData,
    output logic             memWaitrequest,
    output logic [7:0]       wrCount,
    output logic [15:0]      lastAddress,
    output logic [15:0]      lastData
);
    logic [3:0] waited;
    // held busy when idle too, so a writer never relies on a stale low
    assign memWaitrequest = !(memWrite && waited >= stallCycles);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waited      <= 4'h0;
            wrCount     <= 8'h00;
            lastAddress <= 16'h0000;
            lastData    <= 16'h0000;
        end else if (memWrite && !memWaitrequest) begin
            waited      <= 4'h0;
            wrCount     <= wrCount + 8'h01;
            lastAddress <= memAddress;
            lastData    <= memWriteData;
        end else if (memWrite) begin
            waited <= waited + 4'h1;
        end
    end
endmodule : artc_mem_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic        fmt;
        logic [9:0]  raw;
        logic [15:0] want;
    } artc_row_t;
    localparam logic [4:0] A_RES = {1'b0, artc_pkg::OFF_RESULT};
    localparam logic [4:0] A_C0  = {1'b0, artc_pkg::OFF_CTRL0};
    localparam logic [4:0] A_C1  = {1'b0, artc_pkg::OFF_CTRL1};
    localparam logic [4:0] A_SA  = {1'b0, artc_pkg::OFF_START};
    logic        clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable, stallCycles;
    logic [9:0]  convData;
    logic        convDone, memWrite, memWaitrequest, irq;
    logic [15:0] memAddress, memWriteData, lastAddress, lastData;
    logic [7:0]  wrCount, nExp;
    int          n_fail, compares;
    artc_row_t   rows [5] = '{'{1'b0, 10'h3ff, 16'h03ff},
        '{1'b0, 10'h001, 16'h0001}, '{1'b1, 10'h200, 16'h0000},
        '{1'b1, 10'h1ff, 16'hffc0}, '{1'b1, 10'h3ff, 16'h7fc0}};
    artc_transfer u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .convData(convData), .convDone(convDone), .memWrite(memWrite),
        .memAddress(memAddress), .memWriteData(memWriteData),
        .memWaitrequest(memWaitrequest), .irq(irq));
    artc_mem_model u_mem (.clk(clk), .rst(rst), .stallCycles(stallCycles),
        .memWrite(memWrite), .memAddress(memAddress),
        .memWriteData(memWriteData), .memWaitrequest(memWaitrequest),
        .wrCount(wrCount), .lastAddress(lastAddress), .lastData(lastData));
    task check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    // read data is taken at the edge that sees waitrequest low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        @(posedge clk iff (avs_waitrequest === 1'b0));
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : bus
    task rd(input logic [4:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        check(q, want);
    endtask : rd
    task conv(input logic [9:0] v);
        convData <= v;
        convDone <= 1'b1;
        @(posedge clk);
        convDone <= 1'b0;
        @(posedge clk);
    endtask : conv
    // waits for the next memory write, bounded
    task cm(input logic [9:0] v, input logic [15:0] a);
        int i;
        conv(v);
        i = 0;
        while (wrCount == nExp && i < 100) begin
            @(posedge clk);
            i++;
        end
        nExp++;
        check(wrCount, nExp);
        check({lastAddress, lastData}, {a, 6'h00, v});
        repeat (2) @(posedge clk);
    endtask : cm
    task no_write(input logic [9:0] v);
        conv(v);
        repeat (20) @(posedge clk);
        check(wrCount, nExp);
    endtask : no_write
    task give_verdict;
        $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300us;
        n_fail++;
        give_verdict;
    end
    initial begin
        {rst, avs_read, avs_write, convDone} = 4'h8;
        {avs_address, avs_writedata, convData, stallCycles} = '0;
        {avs_byteenable, nExp, n_fail, compares} = {4'hf, 8'h00, 64'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(A_C0, 32'h0);
        rd(A_C1, 32'h0);
        rd(A_SA, 32'h0);
        rd(5'h1c, 32'h0);
        bus(1'b1, A_C0, 32'hf5);
        rd(A_C0, 32'h05);
        bus(1'b1, A_C0, 32'h0);
        $display("end test registers");
        foreach (rows[k]) begin
            bus(1'b1, artc_pkg::OFF_CFG, {31'h0, rows[k].fmt});
            conv(rows[k].raw);
            rd(A_RES, {16'h0, rows[k].want});
        end
        check(wrCount, 8'h00);
        rd(artc_pkg::OFF_STATUS, 32'h2);
        bus(1'b1, artc_pkg::OFF_CFG, 32'h0);
        bus(1'b1, artc_pkg::OFF_MASK, 32'h1);
        $display("end test format");
        bus(1'b1, A_C1, 32'h3);
        bus(1'b1, A_SA, 32'h0101);
        rd(A_SA, 32'h0100);
        cm(10'h011, 16'h0100);
        cm(10'h022, 16'h0102);
        cm(10'h033, 16'h0104);
        check(irq, 1'b1);
        rd(artc_pkg::OFF_STATUS, 32'h1);
        check(irq, 1'b0);
        no_write(10'h044);
        $display("end test one block");
        stallCycles <= 4'h3;
        bus(1'b0, artc_pkg::OFF_STATUS, 32'h0);
        bus(1'b1, A_C0, 32'h8);
        bus(1'b1, A_C1, 32'h2);
        bus(1'b1, A_SA, 32'h0200);
        cm(10'h101, 16'h0200);
        cm(10'h102, 16'h0202);
        rd(A_C0, 32'h08);
        bus(1'b0, artc_pkg::OFF_STATUS, 32'h0);
        bus(1'b1, artc_pkg::OFF_MASK, 32'h0);
        cm(10'h103, 16'h0204);
        cm(10'h104, 16'h0206);
        rd(A_C0, 32'h0a);
        check(irq, 1'b0);
        bus(1'b1, artc_pkg::OFF_MASK, 32'h1);
        check(irq, 1'b1);
        bus(1'b0, artc_pkg::OFF_STATUS, 32'h0);
        no_write(10'h105);
        $display("end test two block");
        stallCycles <= 4'h0;
        bus(1'b1, A_C0, 32'h4);
        bus(1'b1, A_SA, 32'h0300);
        cm(10'h201, 16'h0300);
        cm(10'h202, 16'h0302);
        cm(10'h203, 16'h0300);
        bus(1'b1, A_SA, 32'h0400);
        cm(10'h204, 16'h0400);
        bus(1'b1, A_C0, 32'h0);
        cm(10'h205, 16'h0402);
        no_write(10'h206);
        bus(1'b1, A_C1, 32'h0);
        bus(1'b1, A_SA, 32'h0500);
        no_write(10'h207);
        // low lane only: high byte of the start address is kept
        avs_byteenable <= 4'h1;
        bus(1'b1, A_SA, 32'hff43);
        avs_byteenable <= 4'hf;
        rd(A_SA, 32'h0542);
        $display("end test continuous");
        // reset in mid-run, right after the block's second write is accepted
        bus(1'b1, A_C1, 32'h2);
        bus(1'b1, A_C0, 32'h4);
        bus(1'b1, A_SA, 32'h0600);
        cm(10'h301, 16'h0600);
        conv(10'h302);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        nExp = 8'h00;
        rd(A_C0, 32'h0);
        rd(A_C1, 32'h0);
        rd(A_SA, 32'h0);
        no_write(10'h303);
        check(irq, 1'b0);
        rd(artc_pkg::OFF_STATUS, 32'h2);
        $display("end test reset");
        give_verdict;
    end
endmodule : tb
